// *** orr_pkg.sv ***
package orr_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ORR_DATA_W = 32;
    localparam int ORR_ADDR_W = 8;
    localparam logic [7:0] ORR_OFS_REGION = 8'h00;
    localparam logic [7:0] ORR_OFS_CTRL = 8'h04;
    localparam logic [7:0] ORR_OFS_STATUS = 8'h08;
    localparam logic [7:0] ORR_OFS_LAST_ADDR = 8'h0C;
    localparam logic [7:0] ORR_OFS_PRED_SEL = 8'h10;
    localparam logic [7:0] ORR_OFS_PRED_DATA = 8'h14;
    localparam logic [7:0] ORR_OFS_IDX_SEL = 8'h18;
    localparam logic [7:0] ORR_OFS_IDX_DATA = 8'h1C;

    localparam int ORR_REGION_W = 19;
    localparam logic [18:0] ORR_REGION_RST = 19'h00000;
    localparam int ORR_CTRL_START = 0;
    localparam int ORR_ST_BUSY = 0;
    localparam int ORR_ST_DONE = 1;
    localparam int ORR_ST_ERR = 2;

    // ------------------------------------------------------------
    // Region fields and limits
    // ------------------------------------------------------------
    localparam logic [2:0] ORR_VS_CODE_MAX = 3'h5;
    localparam logic [2:0] ORR_WIDTH_CODE_MAX = 3'h4;
    localparam logic [4:0] ORR_ELEMENT_INDEX_IN_REGISTER_MAX_BYTE = 5'h1F;
    localparam int ORR_OFS_W = 10;
    localparam int ORR_BADDR_W = 16;
    localparam int ORR_IDX_LANES = 16;
    localparam int ORR_IDX_W = 16;
    localparam int ORR_PRED_HALF_W = 16;

    typedef enum logic [1:0] {
        ORR_TYPE_B = 2'h0,
        ORR_TYPE_W = 2'h1,
        ORR_TYPE_D = 2'h2,
        ORR_TYPE_Q = 2'h3
    } orr_etype_t;

    typedef enum logic [1:0] {
        ORR_IDLE = 2'b01,
        ORR_WALK = 2'b10
    } orr_state_t;

    typedef struct packed {
        logic [3:0] rows_m1;
        logic [4:0] element_index_in_register;
        orr_etype_t etype;
        logic [1:0] hs_code;
        logic [2:0] width_code;
        logic [2:0] vs_code;
    } orr_region_t;

    // Horizontal step codes 0..3 map to 0, 1, 2, 4 elements
    function automatic logic [ORR_OFS_W-1:0] orr_hs_elems(
        input logic [1:0] code);
        logic [ORR_OFS_W-1:0] v;
        v = '0;
        case (code)
            2'h0: v = 10'h000;
            2'h1: v = 10'h001;
            2'h2: v = 10'h002;
            default: v = 10'h004;
        endcase
        return v;
    endfunction

    function automatic logic [ORR_OFS_W-1:0] orr_vs_elems(
        input logic [2:0] code);
        return ORR_OFS_W'(10'h001 << code);
    endfunction

    function automatic logic [3:0] orr_width_m1(input logic [2:0] code);
        return 4'(5'h01 << code) - 4'h1;
    endfunction

    // Index limited to whole elements inside one 32-byte register
    function automatic logic orr_region_legal(input orr_region_t r);
        return (r.vs_code <= ORR_VS_CODE_MAX) &&
               (r.width_code <= ORR_WIDTH_CODE_MAX) &&
               (r.element_index_in_register <= (ORR_ELEMENT_INDEX_IN_REGISTER_MAX_BYTE >> r.etype));
    endfunction

endpackage

// *** orr_lane_mem.sv ***
`timescale 1ns/1ps
module orr_lane_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("orr_lane_mem: bad geometry");
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end

endmodule

// *** orr_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - After each row, advance row start by row step: 1,2,4,8,16,32.
// - Row width is elements fetched per row: 1,2,4,8 or 16.
// - Step between elements in a row is 0,1,2 or 4 elements.
// - Element index counts in element-size units, not bytes.
// - Index limit 0-3 for 8-byte and 0-7 for 4-byte types.
// - Index limit 31 for bytes and 15 for words.
// - Two predicate registers, each with selectable halves 0 and 1.
// - One index register with lanes 0 to 15 for indirect access.
// - A region is row step, width and column step applied together.
module orr_top
    import orr_pkg::*;
#(
    parameter int IDX_LANES = ORR_IDX_LANES,
    parameter int IDX_W = ORR_IDX_W
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ORR_ADDR_W-1:0] paddr_i,
    input wire logic [ORR_DATA_W-1:0] pwdata_i,
    output logic [ORR_DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Decoder region request
    input wire logic dec_valid_i,
    input wire orr_region_t dec_region_i,
    output logic dec_ready_o,
    // Register file read port
    output logic rf_rd_valid_o,
    output logic [ORR_BADDR_W-1:0] rf_rd_addr_o,
    output logic rf_walk_done_o,
    // Selected predicate half and index lane
    output logic [ORR_PRED_HALF_W-1:0] pred_half_data_o,
    output logic [IDX_W-1:0] idx_lane_data_o
);

    initial begin
        if (IDX_LANES != ORR_IDX_LANES || IDX_W < 1 || IDX_W > 32) begin
            $error("orr_top: unsupported index register geometry");
        end
    end

    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a <= ORR_OFS_IDX_DATA) && (a[1:0] == 2'h0);
    endfunction

    logic apb_ld;
    logic apb_wr;
    assign apb_ld = psel_i && penable_i && !pready_o;
    assign apb_wr = psel_i && penable_i && pready_o && pwrite_i &&
                    addr_mapped(paddr_i);

    orr_region_t region_cfg_r;
    logic [1:0] pred_sel_r;
    logic [31:0] pred_r [2];
    logic [3:0] idx_sel_r;
    logic done_r;
    logic err_r;
    orr_state_t state_r;
    orr_region_t cfg_r;
    logic [IDX_W-1:0] idx_rd;

    logic apb_start;
    logic dec_take;
    logic start_any;
    orr_region_t start_region;
    logic start_legal;
    logic walk_last;
    logic row_end;

    // Extra wait cycle lets index lane reads see a write just made
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= apb_ld;
            if (apb_ld) begin
                pslverr_o <= !addr_mapped(paddr_i);
                prdata_o <= '0;
                if (paddr_i == ORR_OFS_REGION) begin
                    prdata_o <= 32'(region_cfg_r);
                end else if (paddr_i == ORR_OFS_STATUS) begin
                    prdata_o[ORR_ST_BUSY] <= (state_r == ORR_WALK);
                    prdata_o[ORR_ST_DONE] <= done_r;
                    prdata_o[ORR_ST_ERR] <= err_r;
                end else if (paddr_i == ORR_OFS_LAST_ADDR) begin
                    prdata_o <= 32'(rf_rd_addr_o);
                end else if (paddr_i == ORR_OFS_PRED_SEL) begin
                    prdata_o <= 32'(pred_sel_r);
                end else if (paddr_i == ORR_OFS_PRED_DATA) begin
                    prdata_o <= 32'(pred_half_data_o);
                end else if (paddr_i == ORR_OFS_IDX_SEL) begin
                    prdata_o <= 32'(idx_sel_r);
                end else if (paddr_i == ORR_OFS_IDX_DATA) begin
                    prdata_o <= 32'(idx_rd);
                end
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            region_cfg_r <= ORR_REGION_RST;
            pred_sel_r <= 2'h0;
            idx_sel_r <= 4'h0;
        end else if (apb_wr) begin
            if (paddr_i == ORR_OFS_REGION) begin
                region_cfg_r <= pwdata_i[ORR_REGION_W-1:0];
            end else if (paddr_i == ORR_OFS_PRED_SEL) begin
                pred_sel_r <= pwdata_i[1:0];
            end else if (paddr_i == ORR_OFS_IDX_SEL) begin
                idx_sel_r <= pwdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Predicate registers and index register
    // ------------------------------------------------------------
    // pred_sel_r[1] picks the register, pred_sel_r[0] the half
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pred_r[0] <= 32'h0000_0000;
            pred_r[1] <= 32'h0000_0000;
        end else if (apb_wr && paddr_i == ORR_OFS_PRED_DATA) begin
            if (pred_sel_r[0]) begin
                pred_r[pred_sel_r[1]][31:16] <= pwdata_i[15:0];
            end else begin
                pred_r[pred_sel_r[1]][15:0] <= pwdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pred_half_data_o <= '0;
        end else begin
            pred_half_data_o <= pred_sel_r[0] ?
                pred_r[pred_sel_r[1]][31:16] :
                pred_r[pred_sel_r[1]][15:0];
        end
    end

    // Lane select drives the read address, so reads need no decode
    orr_lane_mem #(
        .DEPTH(IDX_LANES),
        .WIDTH(IDX_W)
    ) u_index_reg (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(apb_wr && paddr_i == ORR_OFS_IDX_DATA),
        .wr_addr_i(idx_sel_r),
        .wr_data_i(pwdata_i[IDX_W-1:0]),
        .rd_addr_i(idx_sel_r),
        .rd_data_o(idx_rd)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            idx_lane_data_o <= '0;
        end else begin
            idx_lane_data_o <= idx_rd;
        end
    end

    // ------------------------------------------------------------
    // Region walker
    // ------------------------------------------------------------
    logic [ORR_OFS_W-1:0] row_start_r;
    logic [ORR_OFS_W-1:0] elem_r;
    logic [3:0] col_r;
    logic [3:0] row_r;

    // Decoder wins a tie; a colliding software start is dropped
    assign dec_take = dec_valid_i && dec_ready_o;
    assign apb_start = apb_wr && paddr_i == ORR_OFS_CTRL &&
                       pwdata_i[ORR_CTRL_START] && state_r == ORR_IDLE &&
                       !dec_take;
    assign start_any = dec_take || apb_start;
    assign start_region = dec_take ? dec_region_i : region_cfg_r;
    assign start_legal = orr_region_legal(start_region);
    assign row_end = col_r == orr_width_m1(cfg_r.width_code);
    assign walk_last = state_r == ORR_WALK && row_end &&
                       row_r == cfg_r.rows_m1;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_r <= ORR_IDLE;
            cfg_r <= ORR_REGION_RST;
            row_start_r <= '0;
            elem_r <= '0;
            col_r <= 4'h0;
            row_r <= 4'h0;
        end else begin
            case (state_r)
                ORR_IDLE: begin
                    if (start_any && start_legal) begin
                        state_r <= ORR_WALK;
                        cfg_r <= start_region;
                        row_start_r <= ORR_OFS_W'(start_region.element_index_in_register);
                        elem_r <= ORR_OFS_W'(start_region.element_index_in_register);
                        col_r <= 4'h0;
                        row_r <= 4'h0;
                    end
                end
                ORR_WALK: begin
                    if (row_end) begin
                        col_r <= 4'h0;
                        if (row_r == cfg_r.rows_m1) begin
                            state_r <= ORR_IDLE;
                        end else begin
                            row_r <= row_r + 4'h1;
                            row_start_r <= row_start_r +
                                orr_vs_elems(cfg_r.vs_code);
                            elem_r <= row_start_r +
                                orr_vs_elems(cfg_r.vs_code);
                        end
                    end else begin
                        col_r <= col_r + 4'h1;
                        elem_r <= elem_r +
                            orr_hs_elems(cfg_r.hs_code);
                    end
                end
                default: begin
                    state_r <= ORR_IDLE;
                end
            endcase
        end
    end

    // Address is in element units until here, bytes after the shift
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rf_rd_valid_o <= 1'b0;
            rf_rd_addr_o <= '0;
            rf_walk_done_o <= 1'b0;
            dec_ready_o <= 1'b0;
        end else begin
            rf_rd_valid_o <= state_r == ORR_WALK;
            if (state_r == ORR_WALK) begin
                rf_rd_addr_o <=
                    ORR_BADDR_W'(elem_r) << cfg_r.etype;
            end
            rf_walk_done_o <= walk_last;
            dec_ready_o <= (state_r == ORR_IDLE && !(start_any &&
                start_legal)) || walk_last;
        end
    end

    // Status flags: hardware set beats a write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            if (walk_last) begin
                done_r <= 1'b1;
            end else if (apb_wr && paddr_i == ORR_OFS_STATUS &&
                         pwdata_i[ORR_ST_DONE]) begin
                done_r <= 1'b0;
            end
            if (start_any && !start_legal) begin
                err_r <= 1'b1;
            end else if (apb_wr && paddr_i == ORR_OFS_STATUS &&
                         pwdata_i[ORR_ST_ERR]) begin
                err_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [ORR_OFS_W-1:0] ref_elem;
    assign ref_elem = ORR_OFS_W'(cfg_r.element_index_in_register) +
        ORR_OFS_W'(row_r * orr_vs_elems(cfg_r.vs_code)) +
        ORR_OFS_W'(col_r * orr_hs_elems(cfg_r.hs_code));

    AST_ROW_ADVANCE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (state_r == ORR_WALK && row_end && !walk_last) |=>
        (elem_r == $past(row_start_r) + orr_vs_elems(cfg_r.vs_code)))
        else $error("row start did not advance by row step");

    AST_ROW_WIDTH: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (state_r == ORR_WALK) |->
        (col_r <= orr_width_m1(cfg_r.width_code)))
        else $error("column count beyond row width");

    AST_COL_STEP: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (state_r == ORR_WALK && !row_end) |=>
        (elem_r == $past(elem_r) + orr_hs_elems(cfg_r.hs_code)))
        else $error("column step wrong");

    AST_TYPE_SCALE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (state_r == ORR_WALK) |=> (rf_rd_valid_o &&
        rf_rd_addr_o == (ORR_BADDR_W'($past(elem_r)) << cfg_r.etype)))
        else $error("byte address not scaled by type size");

    AST_ELEMENT_INDEX_IN_REGISTER_LIMIT: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (start_any && start_region.element_index_in_register >
         (ORR_ELEMENT_INDEX_IN_REGISTER_MAX_BYTE >> start_region.etype)) |=>
        (state_r == ORR_IDLE && err_r && !rf_rd_valid_o))
        else $error("out of range index started a walk");

    AST_LEGAL_START: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (start_any && start_legal) |=> (state_r == ORR_WALK &&
        elem_r == ORR_OFS_W'($past(start_region.element_index_in_register))) ##1 rf_rd_valid_o)
        else $error("legal region did not start");

    AST_PRED_HALF: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        $stable(pred_sel_r) && pred_sel_r == 2'h3 ##1 $stable(pred_sel_r) |->
        pred_half_data_o == $past(pred_r[1][31:16]))
        else $error("predicate half select wrong");

    AST_INDEX_LANE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (apb_wr && paddr_i == ORR_OFS_IDX_DATA) |-> ##3
        (idx_lane_data_o == $past(pwdata_i[IDX_W-1:0], 3)))
        else $error("index lane did not return written value");

    AST_REGION_FORMULA: assert property (
        @(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (state_r == ORR_WALK) |-> (elem_r == ref_elem))
        else $error("element offset does not match region formula");

endmodule

// *** orr_dec_model.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------
// Decoder stand-in: holds each region until the block takes it
// --------------------------------------------------------------
module orr_dec_model
    import orr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Bench control
    input wire logic req_i,
    input wire orr_region_t region_i,
    input wire logic [3:0] delay_i,
    // Decoder side of the block
    input wire logic dec_ready_i,
    output logic dec_valid_o,
    output orr_region_t dec_region_o
);
    logic [3:0] wait_r;
    logic pend_r;

    // Every requested region goes out after the delay, legal or not; there is no check
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pend_r <= 1'b0;
            wait_r <= 4'h0;
            dec_valid_o <= 1'b0;
            dec_region_o <= '0;
        end else if (req_i) begin
            pend_r <= 1'b1;
            wait_r <= delay_i;
            dec_region_o <= region_i;
        end else if (pend_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (pend_r) begin
            pend_r <= 1'b0;
            dec_valid_o <= 1'b1;
        end else if (dec_valid_o && dec_ready_i) begin
            dec_valid_o <= 1'b0;
            // Released bus must not keep showing the taken region
            dec_region_o <= ~dec_region_o;
        end
    end
endmodule

// *** test_operand_region_addressing.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
        end \
    end
module test_operand_region_addressing
    import orr_pkg::*;
;
    typedef struct {orr_region_t rgn; int n; logic [15:0] last;} orr_row_t;
    logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, req = 1'b0, dec_valid, dec_ready;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, re, done, rd_valid;
    logic [3:0] dly = 4'h0;
    logic [15:0] rd_addr, pred_data, idx_data;
    orr_region_t rgn = '0, dec_region;
    orr_row_t rows[6];
    orr_region_t bad[4];
    logic [15:0] got[$];
    int n_errors = 0, check_count = 0, n_done = 0, lone = 0, cycles = 0;
    int lanes[3] = '{0, 9, 15};

    always #25 clk_sys = ~clk_sys;

    orr_top u_orr_top (.clk_sys_i(clk_sys), .reset_n_i(reset_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .dec_valid_i(dec_valid),
        .dec_region_i(dec_region), .dec_ready_o(dec_ready),
        .rf_rd_valid_o(rd_valid), .rf_rd_addr_o(rd_addr),
        .rf_walk_done_o(done), .pred_half_data_o(pred_data),
        .idx_lane_data_o(idx_data));
    orr_dec_model u_orr_dec_model (.clk_sys_i(clk_sys), .reset_n_i(reset_n),
        .req_i(req), .region_i(rgn), .delay_i(dly), .dec_ready_i(dec_ready),
        .dec_valid_o(dec_valid), .dec_region_o(dec_region));

    // --------------------------------------------------------------
    // Monitor and timeout
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) got.push_back(rd_addr);
        if (done === 1'b1) n_done++;
        if (done === 1'b1 && rd_valid !== 1'b1) lone++;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Run cut short by the cycle limit");
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Bus and walk helpers
    // --------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input orr_region_t r, input logic [3:0] dl,
                       input logic by_apb, input int lim);
        int k, d0;
        k = 0;
        d0 = n_done;
        got.delete();
        if (by_apb) begin
            apb(1'b1, ORR_OFS_REGION, 32'(r));
            apb(1'b1, ORR_OFS_CTRL, 32'h1);
        end else begin
            @(posedge clk_sys);
            req <= 1'b1;
            rgn <= r;
            dly <= dl;
            @(posedge clk_sys);
            req <= 1'b0;
        end
        while (n_done == d0 && k < lim) begin
            @(posedge clk_sys);
            k++;
        end
        @(posedge clk_sys);
    endtask

    task automatic check_walk(input orr_region_t r, input int n,
                              input logic [15:0] last);
        int x;
        logic [15:0] e;
        x = 0;
        `CHK("count", n, got.size())
        for (int i = 0; i <= int'(r.rows_m1); i++) begin
            for (int j = 0; j < (1 << r.width_code); j++) begin
                e = 16'((r.element_index_in_register + i * (1 << r.vs_code) +
                    j * (r.hs_code == 2'h3 ? 4 : r.hs_code)) << r.etype);
                if (x < got.size()) `CHK("elem", e, got[x])
                x++;
            end
        end
        `CHK("last", last, got[got.size() - 1])
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rows[0] = '{'{4'h0, 5'h1F, ORR_TYPE_B, 2'h0, 3'h0, 3'h0}, 1, 16'h001F};
        rows[1] = '{'{4'h1, 5'h03, ORR_TYPE_B, 2'h1, 3'h4, 3'h5}, 32, 16'h0032};
        rows[2] = '{'{4'h2, 5'h07, ORR_TYPE_D, 2'h3, 3'h2, 3'h1}, 12, 16'h005C};
        rows[3] = '{'{4'h3, 5'h03, ORR_TYPE_Q, 2'h2, 3'h1, 3'h3}, 8, 16'h00E8};
        rows[4] = '{'{4'h0, 5'h0F, ORR_TYPE_W, 2'h0, 3'h3, 3'h2}, 8, 16'h001E};
        rows[5] = '{'{4'h1, 5'h00, ORR_TYPE_W, 2'h1, 3'h0, 3'h4}, 2, 16'h0020};
        bad = '{'{4'h0, 5'h00, ORR_TYPE_B, 2'h1, 3'h0, 3'h6},
                '{4'h0, 5'h00, ORR_TYPE_B, 2'h1, 3'h5, 3'h0},
                '{4'h0, 5'h08, ORR_TYPE_D, 2'h1, 3'h0, 3'h0},
                '{4'h0, 5'h04, ORR_TYPE_Q, 2'h1, 3'h0, 3'h0}};
        repeat (8) @(posedge clk_sys);
        `CHK("rst valid", 1'b0, rd_valid)
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK("ready", 1'b1, dec_ready)
        $display("Reset test done");
        for (int k = 0; k < 6; k++) begin
            run(rows[k].rgn, 4'(k), k[0], 300);
            check_walk(rows[k].rgn, rows[k].n, rows[k].last);
        end
        `CHK("lone done", 0, lone)
        apb(1'b0, ORR_OFS_LAST_ADDR, 32'h0);
        `CHK("last reg", 32'h20, rq)
        $display("Region table test done");
        foreach (bad[k]) begin
            run(bad[k], 4'h0, 1'b0, 20);
            `CHK("no walk", 0, got.size())
            apb(1'b0, ORR_OFS_STATUS, 32'h0);
            `CHK("err", 1'b1, rq[ORR_ST_ERR])
            apb(1'b1, ORR_OFS_STATUS, 32'h6);
        end
        apb(1'b0, ORR_OFS_STATUS, 32'h0);
        `CHK("status clr", 32'h0, rq)
        $display("Illegal region test done");
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, ORR_OFS_PRED_SEL, 32'(p));
            apb(1'b1, ORR_OFS_PRED_DATA, 32'h1111 * (p + 1));
        end
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, ORR_OFS_PRED_SEL, 32'(p));
            apb(1'b0, ORR_OFS_PRED_DATA, 32'h0);
            `CHK("pred rd", 16'(32'h1111 * (p + 1)), rq[15:0])
            repeat (2) @(posedge clk_sys);
            `CHK("pred out", 16'(32'h1111 * (p + 1)), pred_data)
        end
        foreach (lanes[l]) begin
            apb(1'b1, ORR_OFS_IDX_SEL, 32'(lanes[l]));
            apb(1'b1, ORR_OFS_IDX_DATA, 32'hC000 + lanes[l]);
        end
        foreach (lanes[l]) begin
            apb(1'b1, ORR_OFS_IDX_SEL, 32'(lanes[l]));
            apb(1'b0, ORR_OFS_IDX_DATA, 32'h0);
            `CHK("idx rd", 16'(32'hC000 + lanes[l]), rq[15:0])
            repeat (3) @(posedge clk_sys);
            `CHK("idx out", 16'(32'hC000 + lanes[l]), idx_data)
        end
        $display("Predicate and index test done");
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 33'h100000000, {re, rq})
        apb(1'b1, 8'h02, 32'h1);
        `CHK("misaligned", 1'b1, re)
        run(rows[1].rgn, 4'h0, 1'b0, 10);
        apb(1'b1, ORR_OFS_CTRL, 32'h1);
        apb(1'b0, ORR_OFS_STATUS, 32'h0);
        `CHK("busy", 32'h1, rq)
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("rst mid", 1'b0, rd_valid)
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK("ready again", 1'b1, dec_ready)
        apb(1'b0, ORR_OFS_REGION, 32'h0);
        `CHK("region rst", 32'h0, rq)
        $display("Refusal and reset test done");
        wrap_up();
    end
endmodule
